// *** bench/rdwt_pin_model.sv ***
// Supply supervisor model that pulls the shared reset pin low on request.
// Assumes the bench clock; the pin idles high through its weak pull-up.
`default_nettype none

module rdwt_pin_model (
    input  wire logic        clk_in,
    input  wire logic        hold_req_in,
    input  wire logic [15:0] hold_len_in,
    output logic             pin_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] left_q = 16'h0000;

    // Released pin returns to the pull-up level, never holds its last value
    assign pin_out = (left_q == 16'h0000);

    always @(posedge clk_in) begin
        if (hold_req_in) begin
            left_q <= hold_len_in;
        end else if (left_q != 16'h0000) begin
            left_q <= left_q - 16'h0001;
        end
    end

endmodule : rdwt_pin_model

`default_nettype wire

// *** bench/rdwt_top_tb.sv ***
// Self-checking bench: power-on, pin, watchdog, sleep and register scenarios.
// Assumes shortened delay counts and a supervisor model on the reset pin.
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))

module rdwt_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int POR = 40;
    localparam int WDOG = 20;
    localparam int SUB = 500;

    logic                    clk_in       = 1'h0;
    logic                    rst_n_in     = 1'h0;
    logic [11:0]             cfg_word_in  = 12'h014;
    logic [3:0]              instr_q      = 4'h0;
    rdwt_pkg::rdwt_bus_req_t bus_q        = '0;
    logic                    pin;
    logic [7:0]              rd_data_out;
    logic                    chip_reset_out;
    logic                    flag_n;
    logic                    sleeping_out;
    logic                    gpio;
    logic                    irq_out;
    int                      error_cnt    = 0;
    int                      total_checks = 0;
    int                      cyc          = 0;
    int                      n;
    int                      t;
    logic [7:0]              d;
    logic [2:0]              ps;
    logic                    pre_on;

    always #10 clk_in = ~clk_in;

    rdwt_pin_model SUP (.clk_in(clk_in), .hold_req_in(instr_q[3]),
        .hold_len_in(16'h001e), .pin_out(pin));

    rdwt_top #(.DLY_POR_CYC(24'(POR)), .WDOG_BASE_CYC(24'(WDOG))) DUT (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_word_in(cfg_word_in),
        .ext_reset_pin_in(pin), .watchdog_clear_instr_in(instr_q[0]),
        .sleep_instr_in(instr_q[1]), .pin_change_wake_in(instr_q[2]),
        .bus_req_in(bus_q), .rd_data_out(rd_data_out), .chip_reset_out(chip_reset_out),
        .timeout_flag_n_out(flag_n), .sleeping_out(sleeping_out),
        .pin_is_gpio_out(gpio), .irq_out(irq_out));

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_in);
        bus_q <= '{addr: a, wdata: v, wr: w, rd: !w};
        @(posedge clk_in);
        bus_q <= '0;
        #1;
        d = rd_data_out;
    endtask : bus

    // Bit 0 clear, 1 sleep, 2 pin change, 3 supervisor pull-low
    task automatic instr(input logic [3:0] s);
        @(posedge clk_in);
        instr_q <= s;
        @(posedge clk_in);
        instr_q <= 4'h0;
        #1;
    endtask : instr

    // Bounded wait; n tells how many cycles passed
    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        while (chip_reset_out !== lvl && n < lim) begin
            @(posedge clk_in);
            #1;
            n++;
        end
    endtask : wait_rst

    task automatic por(input logic [11:0] cfg);
        @(posedge clk_in);
        rst_n_in    <= 1'h0;
        cfg_word_in <= cfg;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'h1;
        #1;
        `CHK(chip_reset_out, 1);
        wait_rst(1'h0, 200);
        `CHK(n >= POR && n <= POR + 8, 1);
    endtask : por

    // Cut a hang short well above the expected run length
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(97778));
        por(12'h014);
        bus(1'h0, rdwt_pkg::ADDR_IRQ_STAT, 8'h00);
        `CHK(d, 8'h02);
        bus(1'h1, rdwt_pkg::ADDR_IRQ_MASK, 8'hff);
        bus(1'h0, rdwt_pkg::ADDR_IRQ_MASK, 8'h00);
        `CHK(d, 8'h07);
        bus(1'h0, rdwt_pkg::ADDR_OPTION, 8'h00);
        `CHK(d, 8'h00);
        $display("test power-on done");

        instr(4'h8);
        wait_rst(1'h1, 10);
        `CHK(n <= 5, 1);
        `CHK(irq_out, 1);
        wait_rst(1'h0, 700);
        `CHK(n >= SUB + 25 && n <= SUB + 37, 1);
        `CHK(flag_n, 1);
        bus(1'h0, rdwt_pkg::ADDR_IRQ_STAT, 8'h00);
        `CHK(d, 8'h06);
        @(posedge clk_in);
        #1;
        `CHK(irq_out, 0);
        $display("test pin reset done");

        por(12'h000);
        instr(4'h8);
        bus(1'h1, rdwt_pkg::ADDR_OPTION, 8'h00);
        wait_rst(1'h1, 200);
        `CHK(n, 200);
        `CHK(gpio, 1);
        $display("test gpio and watchdog off done");

        por(12'h014);
        for (int i = 0; i < 4; i++) begin
            pre_on = 1'($urandom_range(0, 1));
            ps     = 3'($urandom_range(0, 3));
            t      = pre_on ? WDOG << ps : WDOG;
            instr(4'h1);
            bus(1'h1, rdwt_pkg::ADDR_OPTION, {4'h0, pre_on, ps});
            wait_rst(1'h1, 400);
            `CHK(n + 2 >= t - 2 && n + 2 <= t + 5, 1);
            `CHK(flag_n, 0);
            wait_rst(1'h0, 600);
        end
        // Option back at all ones: longest prescale
        wait_rst(1'h1, 2400);
        `CHK(n, 2400);
        wait_rst(1'h1, 400);
        `CHK(n < 400, 1);
        wait_rst(1'h0, 600);
        $display("test watchdog periods done");

        bus(1'h1, rdwt_pkg::ADDR_OPTION, 8'h00);
        bus(1'h0, rdwt_pkg::ADDR_IRQ_STAT, 8'h00);
        repeat (25) begin
            instr(4'h1);
            repeat ($urandom_range(0, 12)) @(posedge clk_in);
        end
        bus(1'h0, rdwt_pkg::ADDR_IRQ_STAT, 8'h00);
        `CHK(d[0], 0);
        instr(4'h2);
        `CHK(sleeping_out, 1);
        wait_rst(1'h1, 60);
        `CHK(n + 1 >= WDOG - 2 && n + 1 <= WDOG + 5, 1);
        `CHK(flag_n, 0);
        wait_rst(1'h0, 600);
        `CHK(sleeping_out, 0);
        $display("test clear and sleep done");

        instr(4'h2);
        instr(4'h4);
        wait_rst(1'h1, 5);
        `CHK(n < 5, 1);
        `CHK(flag_n, 1);
        // Write during reset must be dropped
        bus(1'h1, rdwt_pkg::ADDR_OPTION, 8'h00);
        wait_rst(1'h0, 600);
        `CHK(n >= SUB - 10 && n <= SUB + 5, 1);
        instr(4'h4);
        wait_rst(1'h1, 100);
        `CHK(n, 100);
        $display("test wake done");
        tally_and_finish();
    end

endmodule : rdwt_top_tb

`default_nettype wire

// *** hdl/rdwt_pkg.sv ***
// Constants, types and register map of the reset delay and watchdog block.
// Assumes a single 50 MHz clock; the 12-bit configuration word is static.
`default_nettype none

package rdwt_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS    = 20;
    localparam int unsigned DLY_POR_TIME_MS   = 18;
    localparam int unsigned DLY_SUB_TIME_US   = 10;
    localparam int unsigned WDOG_BASE_TIME_MS = 18;
    localparam int unsigned CNT_W             = 24;

    localparam logic [CNT_W-1:0] DLY_POR_CYC =
        CNT_W'((DLY_POR_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DLY_SUB_CYC =
        CNT_W'((DLY_SUB_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WDOG_BASE_CYC =
        CNT_W'((WDOG_BASE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Configuration word fields
    localparam int unsigned CFG_W              = 12;
    localparam int unsigned CFG_EXT_RST_EN_BIT = 4;
    localparam int unsigned CFG_WDOG_EN_BIT    = 2;

    // Register offsets
    localparam logic [1:0] ADDR_OPTION   = 2'h0;
    localparam logic [1:0] ADDR_RST_STAT = 2'h1;
    localparam logic [1:0] ADDR_IRQ_STAT = 2'h2;
    localparam logic [1:0] ADDR_IRQ_MASK = 2'h3;

    // Option register fields
    localparam int unsigned OPT_PRE_ASSIGN_BIT = 3;
    localparam int unsigned OPT_PS_HI_BIT = 2;
    localparam logic [7:0]  OPTION_RESET  = 8'hff;

    // Reset status register fields
    localparam int unsigned RST_STAT_TO_N_BIT  = 0;
    localparam int unsigned RST_STAT_POR_BIT   = 1;
    localparam int unsigned RST_STAT_SLEEP_BIT = 2;
    localparam int unsigned RST_STAT_HOLD_BIT  = 3;

    // Interrupt status / mask fields
    localparam int unsigned IRQ_W           = 3;
    localparam int unsigned IRQ_WDOG_BIT    = 0;
    localparam int unsigned IRQ_RELEASE_BIT = 1;
    localparam int unsigned IRQ_EXT_BIT     = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

    typedef enum logic [1:0] {
        PH_HOLD  = 2'b00,
        PH_COUNT = 2'b01,
        PH_RUN   = 2'b10
    } rdwt_phase_t;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rdwt_bus_req_t;

    typedef struct packed {
        rdwt_phase_t      phase;
        logic             por;
        logic             pin_s1;
        logic             pin_s2;
        logic [CNT_W-1:0] dly_cnt;
        logic [CNT_W-1:0] wdog_cnt;
        logic [6:0]       pre_cnt;
        logic [7:0]       option;
        logic             to_n;
        logic             sleeping;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [7:0]       rd_data;
    } rdwt_state_t;

    localparam rdwt_state_t STATE_RESET = '{
        phase:    PH_HOLD,
        por:      1'b1,
        pin_s1:   1'b0,
        pin_s2:   1'b0,
        dly_cnt:  24'h000000,
        wdog_cnt: 24'h000000,
        pre_cnt:  7'h00,
        option:   OPTION_RESET,
        to_n:     1'b1,
        sleeping: 1'b0,
        irq_stat: 3'h0,
        irq_mask: IRQ_MASK_RESET,
        rd_data:  8'h00
    };

endpackage : rdwt_pkg

`default_nettype wire

// *** hdl/rdwt_top.sv ***
// Reset delay timer, reset latch and watchdog with a small register port.
// Assumes all inputs synchronous to clk_in except the reset pin, which is
// synchronised here; rst_n_in low stands for power-on.
//
// Function
// - Enable fuse set makes pin an active-low reset; cleared, reset input inactive.
// - Power-up sets the reset latch and clears the delay timer.
// - Delay timer counts only once the effective reset input is high.
// - Delay timer time-out clears the latch, ending on-chip reset.
// - Processor held in reset while the delay timer is active.
// - Delay about 18 ms after power-on, about 10 us afterwards.
// - Delay timer runs for power-on, pin, watchdog and wake-up resets.
// - Watchdog runs from its own time base, also during sleep.
// - Watchdog time-out gives a full reset, awake or asleep.
// - Watchdog reset clears the active-low timeout flag.
// - Watchdog enable fuse at 0 disables the watchdog permanently.
// - Base time-out 18 ms, prescaler up to 1:128 from option register.
// - Clear-watchdog instruction clears counter and assigned prescaler.
// - Sleep instruction clears counter and assigned prescaler.
// - Option register resets to all ones on every reset; psa bit 3, ratio 2:0.
// - Watchdog enable fuse is configuration bit 2; 1 enables.
// - Watchdog counter cleared on every wake from sleep.
`default_nettype none

module rdwt_top #(
    parameter logic [rdwt_pkg::CNT_W-1:0] DLY_POR_CYC   = rdwt_pkg::DLY_POR_CYC,
    parameter logic [rdwt_pkg::CNT_W-1:0] WDOG_BASE_CYC = rdwt_pkg::WDOG_BASE_CYC
) (
    input  wire logic                       clk_in,
    input  wire logic                       rst_n_in,
    input  wire logic [rdwt_pkg::CFG_W-1:0] cfg_word_in,
    input  wire logic                       ext_reset_pin_in,
    input  wire logic                       watchdog_clear_instr_in,
    input  wire logic                       sleep_instr_in,
    input  wire logic                       pin_change_wake_in,
    input  wire rdwt_pkg::rdwt_bus_req_t    bus_req_in,
    output logic [7:0]                      rd_data_out,
    output logic                            chip_reset_out,
    output logic                            timeout_flag_n_out,
    output logic                            sleeping_out,
    output logic                            pin_is_gpio_out,
    output logic                            irq_out
);

    rdwt_pkg::rdwt_state_t st_q;
    rdwt_pkg::rdwt_state_t st_d;

    logic                       ext_en;
    logic                       wdog_en;
    logic                       pin_high;
    logic                       ext_rst;
    logic                       pre_assign;
    logic [2:0]                 ps_sel;
    logic                       base_hit;
    logic                       wdog_timeout;
    logic                       wake_evt;
    logic [rdwt_pkg::CNT_W-1:0] dly_term;
    logic [rdwt_pkg::IRQ_W-1:0] irq_evt;
    logic [rdwt_pkg::IRQ_W-1:0] irq_clr;

    // Last prescaler count for a ratio of 1:2^sel
    function automatic logic [6:0] prescale_last(input logic [2:0] sel);
        logic [7:0] ratio;
        ratio = 8'h01 << sel;
        return 7'(ratio - 8'h01);
    endfunction : prescale_last

    assign ext_en   = cfg_word_in[rdwt_pkg::CFG_EXT_RST_EN_BIT];
    assign wdog_en  = cfg_word_in[rdwt_pkg::CFG_WDOG_EN_BIT];
    // Tied inactive when the pin is general I/O
    assign pin_high = !ext_en || st_q.pin_s2;
    assign ext_rst  = ext_en && !st_q.pin_s2;
    assign pre_assign = st_q.option[rdwt_pkg::OPT_PRE_ASSIGN_BIT];
    assign ps_sel   = st_q.option[rdwt_pkg::OPT_PS_HI_BIT:0];

    // Base period stands in for the separate RC oscillator; it keeps
    // counting in sleep since only the processor clock stops there.
    assign base_hit = st_q.wdog_cnt == WDOG_BASE_CYC - 24'h000001;
    assign wdog_timeout = wdog_en && st_q.phase == rdwt_pkg::PH_RUN && base_hit
                          && (!pre_assign || st_q.pre_cnt == prescale_last(ps_sel));
    assign wake_evt = st_q.sleeping && pin_change_wake_in;

    // Power-on flag picks the long terminal count
    assign dly_term = st_q.por ? DLY_POR_CYC : rdwt_pkg::DLY_SUB_CYC;

    always_comb begin
        st_d = st_q;
        irq_evt = 3'h0;
        irq_clr = 3'h0;

        // Two flops; only the second is looked at
        st_d.pin_s1 = ext_reset_pin_in;
        st_d.pin_s2 = st_q.pin_s1;

        case (st_q.phase)
            rdwt_pkg::PH_HOLD: begin
                st_d.dly_cnt = 24'h000000;
                if (pin_high) begin
                    st_d.phase = rdwt_pkg::PH_COUNT;
                end
            end
            rdwt_pkg::PH_COUNT: begin
                if (ext_rst) begin
                    st_d.phase   = rdwt_pkg::PH_HOLD;
                    st_d.dly_cnt = 24'h000000;
                end else if (st_q.dly_cnt == dly_term - 24'h000001) begin
                    st_d.phase   = rdwt_pkg::PH_RUN;
                    st_d.por     = 1'b0;
                    st_d.dly_cnt = 24'h000000;
                    irq_evt[rdwt_pkg::IRQ_RELEASE_BIT] = 1'b1;
                end else begin
                    st_d.dly_cnt = st_q.dly_cnt + 24'h000001;
                end
            end
            rdwt_pkg::PH_RUN: begin
                if (ext_rst) begin
                    st_d.phase = rdwt_pkg::PH_HOLD;
                    irq_evt[rdwt_pkg::IRQ_EXT_BIT] = 1'b1;
                end else if (wdog_timeout) begin
                    st_d.phase = rdwt_pkg::PH_COUNT;
                    st_d.to_n  = 1'b0;
                    irq_evt[rdwt_pkg::IRQ_WDOG_BIT] = 1'b1;
                end else if (wake_evt) begin
                    st_d.phase = rdwt_pkg::PH_COUNT;
                end else begin
                    if (base_hit) begin
                        st_d.wdog_cnt = 24'h000000;
                        st_d.pre_cnt  = st_q.pre_cnt + 7'h01;
                    end else begin
                        st_d.wdog_cnt = st_q.wdog_cnt + 24'h000001;
                    end
                    if (watchdog_clear_instr_in || sleep_instr_in) begin
                        st_d.wdog_cnt = 24'h000000;
                        st_d.to_n     = 1'b1;
                        if (pre_assign) begin
                            st_d.pre_cnt = 7'h00;
                        end
                    end
                    if (sleep_instr_in) begin
                        st_d.sleeping = 1'b1;
                    end
                    if (bus_req_in.wr && bus_req_in.addr == rdwt_pkg::ADDR_OPTION) begin
                        st_d.option = bus_req_in.wdata;
                    end
                end
            end
            default: begin
                st_d.phase = rdwt_pkg::PH_HOLD;
            end
        endcase

        // Any reset wakes the part and restarts the watchdog from zero
        if (st_d.phase != rdwt_pkg::PH_RUN) begin
            st_d.option   = rdwt_pkg::OPTION_RESET;
            st_d.wdog_cnt = 24'h000000;
            st_d.pre_cnt  = 7'h00;
            st_d.sleeping = 1'b0;
        end

        // Mask register and readback
        if (bus_req_in.wr && bus_req_in.addr == rdwt_pkg::ADDR_IRQ_MASK) begin
            st_d.irq_mask = bus_req_in.wdata[rdwt_pkg::IRQ_W-1:0];
        end
        st_d.rd_data = 8'h00;
        if (bus_req_in.rd) begin
            case (bus_req_in.addr)
                rdwt_pkg::ADDR_RST_STAT: begin
                    st_d.rd_data[rdwt_pkg::RST_STAT_TO_N_BIT]  = st_q.to_n;
                    st_d.rd_data[rdwt_pkg::RST_STAT_POR_BIT]   = st_q.por;
                    st_d.rd_data[rdwt_pkg::RST_STAT_SLEEP_BIT] = st_q.sleeping;
                    st_d.rd_data[rdwt_pkg::RST_STAT_HOLD_BIT]  =
                        st_q.phase != rdwt_pkg::PH_RUN;
                end
                rdwt_pkg::ADDR_IRQ_STAT: begin
                    st_d.rd_data[rdwt_pkg::IRQ_W-1:0] = st_q.irq_stat;
                    irq_clr = st_q.irq_stat;
                end
                rdwt_pkg::ADDR_IRQ_MASK: begin
                    st_d.rd_data[rdwt_pkg::IRQ_W-1:0] = st_q.irq_mask;
                end
                default: begin
                    st_d.rd_data = 8'h00;
                end
            endcase
        end
        // A new event in the clearing read survives it
        st_d.irq_stat = (st_q.irq_stat & ~irq_clr) | irq_evt;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st_q <= rdwt_pkg::STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data_out        = st_q.rd_data;
    assign chip_reset_out     = st_q.phase != rdwt_pkg::PH_RUN;
    assign timeout_flag_n_out = st_q.to_n;
    assign sleeping_out       = st_q.sleeping;
    assign pin_is_gpio_out    = !ext_en;
    assign irq_out            = |(st_q.irq_stat & st_q.irq_mask);

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_gpio_no_hold: assert property (
        !ext_en && st_q.phase == rdwt_pkg::PH_HOLD |=> st_q.phase == rdwt_pkg::PH_COUNT)
        else $error("pin as I/O did not release hold");

    a_hold_till_high: assert property (
        st_q.phase == rdwt_pkg::PH_HOLD && !pin_high |=> st_q.phase == rdwt_pkg::PH_HOLD
            && st_q.dly_cnt == 24'h000000)
        else $error("delay timer left hold with pin low");

    a_release_at_term: assert property (
        st_q.phase == rdwt_pkg::PH_COUNT && !ext_rst
            && st_q.dly_cnt == dly_term - 24'h000001
        |=> !chip_reset_out && !st_q.por)
        else $error("reset not released at terminal count");

    a_release_cause: assert property (
        $fell(chip_reset_out) |-> $past(st_q.phase) == rdwt_pkg::PH_COUNT
            && $past(st_q.dly_cnt) == $past(dly_term) - 24'h000001)
        else $error("reset released before delay ran out");

    a_sub_delay_len: assert property (
        $fell(chip_reset_out) && !$past(st_q.por, 2)
        |-> $past(st_q.dly_cnt) == rdwt_pkg::DLY_SUB_CYC - 24'h000001)
        else $error("subsequent reset delay wrong length");

    a_wake_resets: assert property (
        st_q.phase == rdwt_pkg::PH_RUN && wake_evt && !ext_rst && !wdog_timeout
        |=> chip_reset_out && st_q.wdog_cnt == 24'h000000 ##1 chip_reset_out)
        else $error("wake-up did not start the delay timer");

    a_wdt_full_reset: assert property (
        wdog_timeout && !ext_rst
        |=> st_q.phase == rdwt_pkg::PH_COUNT && !timeout_flag_n_out && !sleeping_out)
        else $error("watchdog time-out gave no reset");

    a_to_flag_holds: assert property (
        $fell(timeout_flag_n_out) |-> $past(wdog_timeout))
        else $error("timeout flag cleared without watchdog");

    a_wdt_disabled: assert property (
        !wdog_en |-> !wdog_timeout ##1 !$fell(timeout_flag_n_out))
        else $error("disabled watchdog timed out");

    a_clear_instr: assert property (
        st_q.phase == rdwt_pkg::PH_RUN && !ext_rst && !wdog_timeout && !wake_evt
            && watchdog_clear_instr_in && pre_assign
        |=> st_q.wdog_cnt == 24'h000000 && st_q.pre_cnt == 7'h00 && timeout_flag_n_out)
        else $error("clear instruction did not clear watchdog");

    a_sleep_instr: assert property (
        st_q.phase == rdwt_pkg::PH_RUN && !ext_rst && !wdog_timeout && !wake_evt
            && sleep_instr_in
        |=> sleeping_out && st_q.wdog_cnt == 24'h000000)
        else $error("sleep did not restart watchdog");

    a_option_reset: assert property (
        chip_reset_out |-> st_q.option == rdwt_pkg::OPTION_RESET)
        else $error("option register not all ones in reset");

    a_irq_level: assert property (
        $rose(irq_out) |-> $past(irq_evt != 3'h0
            || bus_req_in.wr))
        else $error("interrupt rose without cause");

endmodule : rdwt_top

`default_nettype wire
